// [logic/kwi_top.sv]
/*
 * Port-D keypad wake interrupt: pin synchroniser, request latch,
 * status/control and pin enable registers on a Wishbone slave.
 * Assumes pins are asynchronous and the CPU pulses i_vector_fetch for one
 * cycle when it fetches this interrupt's vector.
 */
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module kwi_top #(
   parameter int unsigned NPINS = kwi_pkg::PINS
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire kwi_pkg::kwi_wb_req_s i_wb,
   output kwi_pkg::kwi_wb_rsp_s o_wb,
   input wire logic [NPINS-1:0] i_keypad_pin,
   input wire logic i_vector_fetch,
   output logic [NPINS-1:0] o_pullup_en,
   output logic [NPINS-1:0] o_force_input,
   output logic o_irq
);
   import kwi_pkg::*;

   // -------------------------------------------------------------
   // pin synchroniser
   // -------------------------------------------------------------
   logic [NPINS-1:0] pin_meta_ff;
   logic [NPINS-1:0] pin_sync_ff;
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         pin_meta_ff <= '1;
         pin_sync_ff <= '1;
      end else begin
         pin_meta_ff <= i_keypad_pin;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   logic [NPINS-1:0] pin_irq_enable_bits_ff;
   logic request_mask_ff;
   logic sensitivity_select_ff;
   logic pending_ff;
   logic wb_ack_ff;
   logic [31:0] wb_dat_ff;

   logic bus_hit;
   logic wr_status;
   logic wr_enable;
   logic request_acknowledge;
   assign bus_hit = i_wb.cyc && i_wb.stb && !wb_ack_ff;
   assign wr_status = bus_hit && i_wb.we && i_wb.sel[0]
      && i_wb.adr == OFS_STATUS_CONTROL;
   assign wr_enable = bus_hit && i_wb.we && i_wb.sel[0]
      && i_wb.adr == OFS_PIN_ENABLE;
   // write-only strobe, nothing stored
   assign request_acknowledge = wr_status && i_wb.dat[BIT_ACK];

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         pin_irq_enable_bits_ff <= RST_PIN_ENABLE[NPINS-1:0];
      end else if (wr_enable) begin
         pin_irq_enable_bits_ff <= i_wb.dat[NPINS-1:0];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         request_mask_ff <= RST_STATUS_CONTROL[BIT_MASK];
         sensitivity_select_ff <= RST_STATUS_CONTROL[BIT_SENS];
      end else if (wr_status) begin
         request_mask_ff <= i_wb.dat[BIT_MASK];
         sensitivity_select_ff <= i_wb.dat[BIT_SENS];
      end
   end

   // -------------------------------------------------------------
   // request latch
   // -------------------------------------------------------------
   // disabled pins count as high so they never block the AND
   logic all_high;
   logic all_high_d_ff;
   logic fall_event;
   logic clear_req;
   logic nxt_pending;
   assign all_high = &(pin_sync_ff | ~pin_irq_enable_bits_ff);

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         all_high_d_ff <= 1'b1;
      end else begin
         all_high_d_ff <= all_high;
      end
   end

   // fall only when all were high; a second pin falling finds one low
   assign fall_event = all_high_d_ff && !all_high;
   assign clear_req = request_acknowledge || i_vector_fetch;

   always_comb begin
      nxt_pending = pending_ff;
      if (clear_req) begin
         // edge mode clears at once; level mode clears only if all pins are already high
         nxt_pending = sensitivity_select_ff && !all_high;
      end
      if (sensitivity_select_ff && !all_high && !pending_ff && !clear_req) begin
         nxt_pending = 1'b1;
      end
      // a new edge wins over a simultaneous acknowledge
      if (fall_event) begin
         nxt_pending = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         pending_ff <= 1'b0;
      end else begin
         pending_ff <= nxt_pending;
      end
   end

   // -------------------------------------------------------------
   // outputs and bus answer
   // -------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_irq <= 1'b0;
         o_pullup_en <= '0;
         o_force_input <= '0;
      end else begin
         o_irq <= nxt_pending && !request_mask_ff;
         o_pullup_en <= pin_irq_enable_bits_ff;
         o_force_input <= pin_irq_enable_bits_ff;
      end
   end

   // one-wait-state answer; unmapped reads give zero
   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         wb_ack_ff <= 1'b0;
         wb_dat_ff <= 32'h0000_0000;
      end else begin
         wb_ack_ff <= bus_hit;
         wb_dat_ff <= 32'h0000_0000;
         if (bus_hit && !i_wb.we) begin
            unique case (i_wb.adr)
               OFS_STATUS_CONTROL: begin
                  // upper nibble and acknowledge read zero
                  wb_dat_ff[BIT_PEND] <= pending_ff;
                  wb_dat_ff[BIT_MASK] <= request_mask_ff;
                  wb_dat_ff[BIT_SENS] <= sensitivity_select_ff;
               end
               OFS_PIN_ENABLE: begin
                  wb_dat_ff[NPINS-1:0] <= pin_irq_enable_bits_ff;
               end
               default: begin
                  wb_dat_ff <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   assign o_wb.ack = wb_ack_ff;
   assign o_wb.dat = wb_dat_ff;
endmodule : kwi_top

// [logic/kwi_pkg.sv]
/*
 * Constants, register map and bus carrier types for the port-D keypad
 * wake interrupt block.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
// What this block does
// - eight enable bits each make one pin an interrupt source; reset clears
// - an enabled pin also has its internal pull-up switched on
// - in edge-and-level mode a low level on an enabled pin latches a keypad request
// - request latches when any enabled pin falls after all were high
// - edge-only mode ignores a fall while another enabled pin is low
// - edge-and-level mode holds the request while any enabled pin is low
// - level mode clears only on an acknowledge given after all pins are high
// - vector fetch or software acknowledge write clears the request
// - a falling edge after the acknowledge write latches a new request
// - unmasked request goes to the CPU, vector at FFEA and FFEB
// - edge-only mode clears the request at once on acknowledge
// - reset clears request and sensitivity even with a pin held low
// - pending flag shows the request whatever the mask says
// - an enabled pin is forced to input, overriding its direction bit
// - status bits seven to four read as zero
// - pending flag reads one while a request is pending; reset clears
// - acknowledge bit is write-only, reads zero, reset clears
// - mask bit one blocks the CPU interrupt; reset clears it
// - sensitivity bit one is edge and level, zero is edge only
package kwi_pkg;
   localparam int unsigned PINS = 8;
   localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_PIN_ENABLE = 4'h4;
   localparam int unsigned BIT_SENS = 0;
   localparam int unsigned BIT_MASK = 1;
   localparam int unsigned BIT_ACK = 2;
   localparam int unsigned BIT_PEND = 3;
   localparam logic [7:0] RST_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] RST_PIN_ENABLE = 8'h00;
   localparam logic [15:0] VECTOR_ADDR = 16'hFFEA;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } kwi_wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } kwi_wb_rsp_s;
endpackage : kwi_pkg

// [verification/kwi_keypad_model.sv]
/* keypad switches on the port pins; pull-up comes from the block */
`timescale 1ns/1ps
module kwi_keypad_model (
   input wire logic i_ref_clk,
   input wire logic [7:0] i_press,
   input wire logic [7:0] i_pullup_en,
   output logic [7:0] o_pin
);
   logic float_ff = 1'b0;
   // an undriven line wanders, so a stale level never looks valid
   always_ff @(posedge i_ref_clk) begin
      float_ff <= ~float_ff;
   end
   // pins are only ever read through the block, never as outputs
   assign o_pin = ~i_press & (i_pullup_en | {8{float_ff}});
endmodule : kwi_keypad_model

// [verification/kwi_top_assertions.sv]
/* port checks for kwi_top; bound below to every instance */
`timescale 1ns/1ps
module kwi_top_assertions import kwi_pkg::*; #(
   parameter int unsigned NPINS = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire kwi_wb_req_s i_wb,
   input wire kwi_wb_rsp_s o_wb,
   input wire logic [NPINS-1:0] i_keypad_pin,
   input wire logic i_vector_fetch,
   input wire logic [NPINS-1:0] o_pullup_en,
   input wire logic [NPINS-1:0] o_force_input,
   input wire logic o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_taken;
      i_wb.cyc && i_wb.stb && !o_wb.ack;
   endsequence
   sequence s_en_wr;
      s_taken ##0 (i_wb.we && i_wb.sel[0] && i_wb.adr == OFS_PIN_ENABLE);
   endsequence
   AST_ACK_ONE: assert property (s_taken |=> o_wb.ack)
      else $error("request not answered next cycle");
   AST_ACK_PULSE: assert property (o_wb.ack |=> !o_wb.ack)
      else $error("ack longer than one cycle");
   AST_PULL_FORCE: assert property (o_pullup_en == o_force_input)
      else $error("force input differs from pull-up");
   AST_RESET: assert property ($rose(i_resetn) |->
      !o_irq && o_pullup_en == '0) else $error("outputs not cleared");
   AST_RD_UPPER: assert property (o_wb.ack |-> o_wb.dat[31:8] == '0)
      else $error("upper read lanes not zero");
   AST_STAT_ZERO: assert property (o_wb.ack && !i_wb.we &&
      i_wb.adr == OFS_STATUS_CONTROL |-> o_wb.dat[7:4] == 4'h0 &&
      !o_wb.dat[BIT_ACK]) else $error("status zero bits set");
   AST_EN_WRITE: assert property (s_en_wr |=> ##1
      o_pullup_en == $past(i_wb.dat[7:0], 2)) else $error("pull-up wrong");
   AST_IRQ_CAUSE: assert property ($rose(o_irq) |->
      $past(i_keypad_pin, 3) != 8'hFF) else $error("irq without low pin");
endmodule : kwi_top_assertions
bind kwi_top kwi_top_assertions #(.NPINS(NPINS)) chk (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_wb(i_wb), .o_wb(o_wb),
   .i_keypad_pin(i_keypad_pin), .i_vector_fetch(i_vector_fetch),
   .o_pullup_en(o_pullup_en), .o_force_input(o_force_input), .o_irq(o_irq));

// [verification/tb_kwi_top.sv]
/* register-level bench for kwi_top; keypad model on the pins */
`timescale 1ns/1ps
module tb_kwi_top;
   import kwi_pkg::*;
   logic clk = 0, rstn = 0, vf = 0, irq;
   logic [7:0] press = 8'h00, pin, pull, frc, q;
   kwi_wb_req_s wb = '0;
   kwi_wb_rsp_s rsp;
   int fails = 0, compares = 0;
   localparam logic [3:0] SC = OFS_STATUS_CONTROL;
   initial forever #12.5 clk = ~clk;
   kwi_top uut (.i_ref_clk(clk), .i_resetn(rstn), .i_wb(wb), .o_wb(rsp),
      .i_keypad_pin(pin), .i_vector_fetch(vf), .o_pullup_en(pull),
      .o_force_input(frc), .o_irq(irq));
   kwi_keypad_model keys (.i_ref_clk(clk), .i_press(press),
      .i_pullup_en(pull), .o_pin(pin));
   task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, logic [7:0] d);
      wb <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
      do @(posedge clk); while (rsp.ack !== 1'b1);
      q = rsp.dat[7:0];
      wb <= '0;
      @(posedge clk);
   endtask : bus
   task automatic rd(input logic [3:0] a, string n, logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(n, e, q);
   endtask : rd
   task automatic end_of_test;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      end_of_test();
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      rd(SC, "status", 8'h00);
      rd(OFS_PIN_ENABLE, "enable", 8'h00);
      rd(4'h8, "unmapped", 8'h00);
      bus(1, SC, 8'h02);
      bus(1, OFS_PIN_ENABLE, 8'hFF);
      repeat (5) @(posedge clk);
      bus(1, SC, 8'h06);
      bus(1, SC, 8'h00);
      chk("pullup", 8'hFF, pull);
      chk("force", 8'hFF, frc);
      press <= 8'h01;
      repeat (5) @(posedge clk);
      chk("irq", 8'h01, {7'h0, irq});
      rd(SC, "status", 8'h08);
      press <= 8'h03;
      bus(1, SC, 8'h04);
      repeat (5) @(posedge clk);
      rd(SC, "status", 8'h00);
      press <= 8'h00;
      repeat (5) @(posedge clk);
      press <= 8'h04;
      repeat (5) @(posedge clk);
      rd(SC, "status", 8'h08);
      vf <= 1;
      @(posedge clk);
      vf <= 0;
      rd(SC, "status", 8'h00);
      bus(1, SC, 8'h02);
      press <= 8'h00;
      repeat (5) @(posedge clk);
      press <= 8'h08;
      repeat (5) @(posedge clk);
      rd(SC, "status", 8'h0A);
      chk("irq", 8'h00, {7'h0, irq});
      bus(1, SC, 8'h03);
      bus(1, SC, 8'h01);
      rd(SC, "status", 8'h09);
      press <= 8'h00;
      repeat (5) @(posedge clk);
      rd(SC, "status", 8'h09);
      bus(1, SC, 8'h05);
      rd(SC, "status", 8'h01);
      // level mode: a held low pin latches and survives the acknowledge
      press <= 8'h01;
      repeat (5) @(posedge clk);
      rd(SC, "status", 8'h09);
      bus(1, SC, 8'h05);
      rd(SC, "status", 8'h09);
      rstn <= 0;
      repeat (2) @(posedge clk);
      rstn <= 1;
      @(posedge clk);
      rd(SC, "status", 8'h00);
      end_of_test();
   end
endmodule : tb_kwi_top
